// File: jads_top.sv
// Test port with two serial data inputs and the logic that chooses between them.
// Assumes all pins are asynchronous to SYS_CLK and TCK is far slower than SYS_CLK.
`timescale 1ns/1ps
module jads_top
    import jads_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic ALTERNATE_DATA_INPUT,
    input wire logic DATA_INPUT_SELECT_PIN,
    output logic DATA_INPUT_SELECT_PULLUP,
    output logic TDO,
    output logic TDO_OE,
    output logic ALT_INPUT_ACTIVE
);

    jads_pins_t sync_a;
    jads_pins_t sync_b;
    logic tck_prev;
    logic tck_rise;
    logic tck_fall;
    jads_tap_t state;
    logic [IR_WIDTH-1:0] ir;
    logic [IR_WIDTH-1:0] ir_shift;
    logic ir_shifted;
    logic [ID_WIDTH-1:0] dr_shift;
    logic [CNT_WIDTH-1:0] id_count;
    logic alt_latched;
    logic data_in;
    logic [IR_WIDTH-1:0] latched_ir;

    // One decode shared by the counter, the latch and the data register
    function automatic logic is_idcode(input logic [IR_WIDTH-1:0] op);
        return op == IR_IDCODE;
    endfunction : is_idcode

    // Pull-up is off in reset and on after it; the pad uses it to default the pin high
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            DATA_INPUT_SELECT_PULLUP <= 1'b0;
        end else begin
            DATA_INPUT_SELECT_PULLUP <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sync_a <= PINS_RESET;
            sync_b <= PINS_RESET;
        end else begin
            sync_a <= '{tck: TCK, tms: TMS, tdi: TDI, alt: ALTERNATE_DATA_INPUT,
                        sel: DATA_INPUT_SELECT_PIN};
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= sync_b.tck;
        end
    end

    assign tck_rise = sync_b.tck & ~tck_prev;
    assign tck_fall = ~sync_b.tck & tck_prev;

    jads_tap u_tap (
        .clk(SYS_CLK),
        .rst(RESET),
        .step(tck_rise),
        .tms(sync_b.tms),
        .state(state)
    );

    // Pin low wins outright; otherwise the latch decides
    assign data_in = (~sync_b.sel | alt_latched) ? sync_b.alt : sync_b.tdi;

    // Skipped Shift-IR keeps the old instruction
    assign latched_ir = ir_shifted ? ir_shift : ir;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ir_shift <= IR_CAPTURE;
            ir_shifted <= 1'b0;
        end else if (tck_rise) begin
            if (state == CIR) begin
                ir_shift <= IR_CAPTURE;
                ir_shifted <= 1'b0;
            end else if (state == SIR) begin
                ir_shift <= {data_in, ir_shift[IR_WIDTH-1:1]};
                ir_shifted <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ir <= IR_IDCODE;
        end else if (state == TLR) begin
            ir <= IR_IDCODE;
        end else if (tck_fall && state == UIR) begin
            ir <= latched_ir;
        end
    end

    // Non-IDCODE instructions fall back to a one-bit bypass in bit 0
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            dr_shift <= '0;
        end else if (tck_rise) begin
            if (state == CDR) begin
                dr_shift <= is_idcode(ir) ? ID_VALUE : '0;
            end else if (state == SDR) begin
                if (is_idcode(ir)) begin
                    dr_shift <= {data_in, dr_shift[ID_WIDTH-1:1]};
                end else begin
                    dr_shift[0] <= data_in;
                end
            end
        end
    end

    // Counting with Shift-IR skipped ignores data pins, so no serial alignment is needed
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            id_count <= '0;
        end else if (state == TLR) begin
            id_count <= '0;
        end else if (tck_fall && state == UIR) begin
            if (!is_idcode(latched_ir)) begin
                id_count <= '0;
            end else if (id_count != IDCODE_RUN) begin
                id_count <= id_count + CNT_ONE;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            alt_latched <= 1'b0;
        end else if (state == TLR) begin
            alt_latched <= 1'b0;
        end else if (tck_fall && state == UIR && is_idcode(latched_ir)
                     && id_count == IDCODE_RUN - CNT_ONE) begin
            alt_latched <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ALT_INPUT_ACTIVE <= 1'b0;
        end else begin
            ALT_INPUT_ACTIVE <= ~sync_b.sel | alt_latched;
        end
    end

    // Output changes on TCK fall so the far end samples a settled bit
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            TDO <= 1'b0;
        end else if (tck_fall) begin
            if (state == SIR) begin
                TDO <= ir_shift[0];
            end else if (state == SDR) begin
                TDO <= dr_shift[0];
            end
        end
    end

    // Enable follows the shift states only, so capture and update leave the line idle
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO_OE <= (state == SIR) || (state == SDR);
        end
    end

endmodule : jads_top

// File: jads_pkg.sv
// Constants, types and state codes for the alternate data input selector.
// Assumes one system clock that samples every test-port pin as a plain input.
package jads_pkg;

    localparam int IR_WIDTH = 8;
    localparam logic [IR_WIDTH-1:0] IR_IDCODE = 8'h01;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 8'h01;
    localparam int ID_WIDTH = 32;
    // Arbitrary neutral value, bit 0 set as a test port requires
    localparam logic [ID_WIDTH-1:0] ID_VALUE = 32'h0000_1001;
    localparam int CNT_WIDTH = 3;
    localparam logic [CNT_WIDTH-1:0] IDCODE_RUN = 3'h4;
    localparam logic [CNT_WIDTH-1:0] CNT_ONE = 3'h1;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic alt;
        logic sel;
    } jads_pins_t;

    // Select pin idles high, matching its pull-up
    localparam jads_pins_t PINS_RESET = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, alt: 1'b0, sel: 1'b1};

    typedef enum logic [15:0] {
        TLR  = 16'h0001,
        RTI  = 16'h0002,
        SDRS = 16'h0004,
        CDR  = 16'h0008,
        SDR  = 16'h0010,
        E1DR = 16'h0020,
        PDR  = 16'h0040,
        E2DR = 16'h0080,
        UDR  = 16'h0100,
        SIRS = 16'h0200,
        CIR  = 16'h0400,
        SIR  = 16'h0800,
        E1IR = 16'h1000,
        PIR  = 16'h2000,
        E2IR = 16'h4000,
        UIR  = 16'h8000
    } jads_tap_t;

endpackage : jads_pkg

// File: jads_tap.sv
// Test access port state machine, stepped once per sampled TCK rise.
// Assumes step is a one-cycle pulse and tms is already synchronised.
`timescale 1ns/1ps
module jads_tap
    import jads_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic tms,
    output jads_tap_t state
);

    jads_tap_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            TLR:  next_state = tms ? TLR : RTI;
            RTI:  next_state = tms ? SDRS : RTI;
            SDRS: next_state = tms ? SIRS : CDR;
            CDR:  next_state = tms ? E1DR : SDR;
            SDR:  next_state = tms ? E1DR : SDR;
            E1DR: next_state = tms ? UDR : PDR;
            PDR:  next_state = tms ? E2DR : PDR;
            E2DR: next_state = tms ? UDR : SDR;
            UDR:  next_state = tms ? SDRS : RTI;
            SIRS: next_state = tms ? TLR : CIR;
            CIR:  next_state = tms ? E1IR : SIR;
            SIR:  next_state = tms ? E1IR : SIR;
            E1IR: next_state = tms ? UIR : PIR;
            PIR:  next_state = tms ? E2IR : PIR;
            E2IR: next_state = tms ? UIR : SIR;
            UIR:  next_state = tms ? SDRS : RTI;
            default: next_state = TLR;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TLR;
        end else if (step) begin
            state <= next_state;
        end
    end

endmodule : jads_tap

// File: jads_sva.sv
// Port checker for the data input selector.
// Assumes TCK phases last six or more system clocks.
`timescale 1ns/1ps
module jads_chk (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic DATA_INPUT_SELECT_PIN,
    input wire logic DATA_INPUT_SELECT_PULLUP,
    input wire logic TDO,
    input wire logic TDO_OE,
    input wire logic ALT_INPUT_ACTIVE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    property p_pull; $past(RESET) == 1'b0 |-> DATA_INPUT_SELECT_PULLUP; endproperty
    property p_low; (!DATA_INPUT_SELECT_PIN)[*5] |-> ALT_INPUT_ACTIVE; endproperty
    property p_rise; $rose(ALT_INPUT_ACTIVE) |-> !TCK || !DATA_INPUT_SELECT_PIN; endproperty
    property p_fall; $fell(ALT_INPUT_ACTIVE) |-> TMS || !$past(DATA_INPUT_SELECT_PIN, 6); endproperty
    property p_tdo; $changed(TDO) |-> !TCK; endproperty
    property p_oe; $changed(TDO_OE) |-> !TCK; endproperty
    property p_idle; $stable(TCK)[*8] |=> $stable(TDO) && $stable(TDO_OE); endproperty
    property p_hold;
        ($stable(TCK) && $stable(DATA_INPUT_SELECT_PIN))[*8] |=> $stable(ALT_INPUT_ACTIVE);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up off");
    a_low: assert property (p_low) else $error("low select ignored");
    a_rise: assert property (p_rise) else $error("odd switch");
    a_fall: assert property (p_fall) else $error("odd release");
    a_tdo: assert property (p_tdo) else $error("TDO off edge");
    a_oe: assert property (p_oe) else $error("OE off edge");
    a_idle: assert property (p_idle) else $error("TDO moved idle");
    a_hold: assert property (p_hold) else $error("select moved idle");
    c_rise: cover property ($rose(ALT_INPUT_ACTIVE) && DATA_INPUT_SELECT_PIN);
    c_fall: cover property ($fell(ALT_INPUT_ACTIVE) && TMS);
    c_oe: cover property ($rose(TDO_OE));
endmodule : jads_chk
bind jads_top jads_chk jads_chk_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .TCK(TCK), .TMS(TMS),
    .DATA_INPUT_SELECT_PIN(DATA_INPUT_SELECT_PIN), .TDO(TDO), .TDO_OE(TDO_OE),
    .DATA_INPUT_SELECT_PULLUP(DATA_INPUT_SELECT_PULLUP), .ALT_INPUT_ACTIVE(ALT_INPUT_ACTIVE));

// File: jads_prog.sv
// Programmer model for the test port pins.
// Assumes its tasks are called one at a time.
`timescale 1ns/1ps
module jads_prog
    import jads_pkg::*;
(
    input wire logic pull_en,
    input wire logic tdo,
    output jads_pins_t pins
);
    logic tck = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b0;
    logic alt = 1'b0;
    logic sel_low = 1'b0;
    logic on_alt = 1'b0;
    // Released pin reads the pull-up
    assign pins = '{tck, tms, tdi, alt, !sel_low && pull_en};
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        // Idle input gets the inverse
        tdi <= on_alt ? ~d : d;
        alt <= on_alt ? d : ~d;
        #62.5 o = tdo;
        tck <= 1'b1;
        #62.5 tck <= 1'b0;
    endtask : step
    task automatic skip_ir(input logic pause);
        logic o;
        logic [7:0] s;
        s = pause ? 8'h6b : 8'h1b;
        o = 1'b0;
        for (int i = 0; i < (pause ? 8 : 6); i++) begin
            step(s[i], ~o, o);
        end
    endtask : skip_ir
endmodule : jads_prog

// File: jads_top_tb.sv
// Self-checking bench for the data input selector.
// Assumes the programmer model owns every test pin.
`timescale 1ns/1ps
module jads_top_tb
    import jads_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    jads_pins_t pins;
    logic pull_en, tdo, tdo_oe, alt_act, o;
    logic [31:0] q, d;
    logic [7:0] op;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 32'h9d0b;
    always #5 sys_clk = ~sys_clk;
    jads_prog jads_prog_inst (.pull_en(pull_en), .tdo(tdo), .pins(pins));
    jads_top jads_top_inst (.SYS_CLK(sys_clk), .RESET(reset), .TCK(pins.tck), .TMS(pins.tms),
        .TDI(pins.tdi), .ALTERNATE_DATA_INPUT(pins.alt), .DATA_INPUT_SELECT_PIN(pins.sel),
        .DATA_INPUT_SELECT_PULLUP(pull_en), .TDO(tdo), .TDO_OE(tdo_oe), .ALT_INPUT_ACTIVE(alt_act));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic st(input logic m, input logic v);
        jads_prog_inst.step(m, v, o);
    endtask : st
    task automatic settle;
        repeat (12) @(posedge sys_clk);
    endtask : settle
    task automatic tap_reset;
        d = $random(seed);
        for (int i = 0; i < 5; i++) st(1'b1, d[i]);
        st(1'b0, d[5]);
    endtask : tap_reset
    task automatic scan(input logic ir, input int n, input logic [31:0] v);
        q = '0;
        st(1'b1, ~o);
        if (ir) st(1'b1, ~o);
        repeat (2) st(1'b0, ~o);
        for (int i = 0; i < n; i++) begin
            st(i == n - 1, v[i]);
            q[i] = o;
            if (i == 0) check(tdo_oe, 1'b1);
        end
        st(1'b1, ~o);
        st(1'b0, ~o);
    endtask : scan
    function automatic logic [7:0] exp_bypass(input logic [7:0] v);
        return {v[6:0], 1'b0};
    endfunction : exp_bypass
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        settle;
        check(pull_en, 1'b1);
        check(alt_act, 1'b0);
        tap_reset;
        scan(1'b0, 32, $random(seed));
        check(q, ID_VALUE);
        check(tdo_oe, 1'b0);
        $display("test idcode done");
        tap_reset;
        repeat (3) jads_prog_inst.skip_ir(1'b0);
        op = ($random(seed) & 8'h7e) | 8'h02;
        scan(1'b1, 8, op);
        check(q[7:0], IR_CAPTURE);
        scan(1'b1, 8, IR_IDCODE);
        repeat (2) jads_prog_inst.skip_ir(1'b1);
        settle;
        check(alt_act, 1'b0);
        jads_prog_inst.skip_ir(1'b1);
        settle;
        check(alt_act, 1'b1);
        $display("test count done");
        jads_prog_inst.on_alt = 1'b1;
        scan(1'b1, 8, op);
        d = $random(seed);
        scan(1'b0, 8, d);
        check(q[7:0], exp_bypass(d[7:0]));
        tap_reset;
        settle;
        check(alt_act, 1'b0);
        $display("test alternate done");
        jads_prog_inst.sel_low <= 1'b1;
        settle;
        check(alt_act, 1'b1);
        tap_reset;
        scan(1'b0, 32, $random(seed));
        check(q, ID_VALUE);
        scan(1'b1, 8, op);
        d = $random(seed);
        scan(1'b0, 8, d);
        check(q[7:0], exp_bypass(d[7:0]));
        jads_prog_inst.sel_low <= 1'b0;
        settle;
        check(alt_act, 1'b0);
        $display("test select pin done");
        conclude;
    end
    initial begin
        #200us;
        mismatches++;
        $display("BAD %0t: timeout", $time);
        conclude;
    end
endmodule : jads_top_tb
